//--- hw/cptr_pkg.sv
// Notes on behaviour
// - Post-increment word: address pointer, then add one.
// - Post-increment long: address pointer, then add two.
// - Post-decrement word: address pointer, then subtract one.
// - Post-decrement long: address pointer, then subtract two.
// - Second address: first plus one if even.
// - First word to lower register, second next.
// - Offset address: high part, pointer, start, offset.
// - Offset mode leaves pointer unchanged.
// - Offset taken from two-byte instruction extension.
// - Offset-mode instruction never paired in parallel.
package cptr_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PTR_W  = 16;
    localparam int HIGH_W = 7;
    localparam int ADDR_W = PTR_W + HIGH_W;
    localparam int REG_W  = 5;
    localparam int EXT_W  = 8;

    localparam logic [PTR_W-1:0]  PTR_RESET  = 16'h0000;
    localparam logic [HIGH_W-1:0] HIGH_RESET = 7'h00;
    localparam logic [PTR_W-1:0]  STEP_WORD  = 16'h0001;
    localparam logic [PTR_W-1:0]  STEP_LONG  = 16'h0002;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PLAIN    = 2'b00,
        MODE_POST_INC = 2'b01,
        MODE_POST_DEC = 2'b10,
        MODE_OFFSET   = 2'b11
    } addr_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXT_L = 2'b01,
        ST_EXT_H = 2'b10
    } fetch_state_e;

endpackage

//--- hw/cptr_pair_addr.sv
`timescale 1ns/1ps
`default_nettype none

// Forms the second address of a long-word access from the first.
module cptr_pair_addr
    import cptr_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // First address in
    input  wire logic [AW-1:0] first_addr,
    // Partner address out
    output logic      [AW-1:0] second_addr
);

    always_comb begin
        if (first_addr[0]) begin
            second_addr = first_addr - AW'(1);
        end else begin
            second_addr = first_addr + AW'(1);
        end
    end

endmodule

`default_nettype wire

//--- hw/coeff_pointer_address_gen.sv
`timescale 1ns/1ps
`default_nettype none

module coeff_pointer_address_gen
    import cptr_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // Pointer load from the CPU
    input  wire logic                ptr_load,
    input  wire logic [PTR_W-1:0]    ptr_load_value,
    input  wire logic                high_load,
    input  wire logic [HIGH_W-1:0]   high_load_value,
    // Circular buffer start
    input  wire logic                circ_enable,
    input  wire logic [PTR_W-1:0]    circular_buffer_start,
    // Access request
    input  wire logic                req_valid,
    input  wire logic [1:0]          req_mode,
    input  wire logic                req_long,
    input  wire logic                req_load,
    input  wire logic [REG_W-1:0]    req_dest_reg,
    // Instruction extension bytes
    input  wire logic                ext_valid,
    input  wire logic [EXT_W-1:0]    ext_byte,
    // Memory answer
    input  wire logic                rd_valid,
    input  wire logic [PTR_W-1:0]    rd_word_first,
    input  wire logic [PTR_W-1:0]    rd_word_second,
    // Address outputs
    output logic                     addr_valid,
    output logic                     addr_long,
    output logic [ADDR_W-1:0]        addr_first,
    output logic [ADDR_W-1:0]        addr_second,
    output logic                     busy,
    output logic                     no_parallel,
    // Register write back
    output logic                     wb_valid,
    output logic                     wb_pair,
    output logic [REG_W-1:0]         wb_reg_lo,
    output logic [PTR_W-1:0]         wb_data_lo,
    output logic [REG_W-1:0]         wb_reg_hi,
    output logic [PTR_W-1:0]         wb_data_hi,
    // Pointer state
    output logic [PTR_W-1:0]         coefficient_pointer,
    output logic [HIGH_W-1:0]        pointer_high_part
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Pointer arithmetic stays inside the low 16 bits and never reaches the high part.
    function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] a,
                                                 input logic [PTR_W-1:0] b);
        ptr_add = a + b;
    endfunction

    function automatic logic [ADDR_W-1:0] join_addr(input logic [HIGH_W-1:0] h,
                                                    input logic [PTR_W-1:0]  p);
        join_addr = {h, p};
    endfunction

    // Subtraction wraps the same way, so a decrement from zero lands at the top.
    function automatic logic [PTR_W-1:0] ptr_sub(input logic [PTR_W-1:0] a,
                                                 input logic [PTR_W-1:0] b);
        ptr_sub = a - b;
    endfunction

    // Word accesses move the pointer by one step and long accesses by two.
    function automatic logic [PTR_W-1:0] step_size(input logic lng);
        step_size = lng ? STEP_LONG : STEP_WORD;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fetch_state_e             state;
    fetch_state_e             next_state;
    logic [EXT_W-1:0]         ext_lo;
    logic [EXT_W-1:0]         next_ext_lo;
    logic                     held_long;
    logic                     next_held_long;
    logic                     held_load;
    logic                     next_held_load;
    logic [REG_W-1:0]         held_reg;
    logic [REG_W-1:0]         next_held_reg;
    logic [REG_W-1:0]         pend_reg;
    logic [REG_W-1:0]         next_pend_reg;
    logic                     pend_long;
    logic                     next_pend_long;
    logic                     pend;
    logic                     next_pend;

    logic [PTR_W-1:0]         next_coefficient_pointer;
    logic [HIGH_W-1:0]        next_pointer_high_part;
    logic                     next_addr_valid;
    logic                     next_addr_long;
    logic [ADDR_W-1:0]        next_addr_first;
    logic                     next_busy;
    logic                     next_no_parallel;
    logic                     next_wb_valid;
    logic                     next_wb_pair;
    logic [REG_W-1:0]         next_wb_reg_lo;
    logic [PTR_W-1:0]         next_wb_data_lo;
    logic [REG_W-1:0]         next_wb_reg_hi;
    logic [PTR_W-1:0]         next_wb_data_hi;

    logic [PTR_W-1:0]         base_ptr;
    logic [PTR_W-1:0]         offset_k;
    logic [ADDR_W-1:0]        pair_addr;

    // Effective base with the optional circular start folded in.
    // The circular inputs are read when the address is formed, so for an offset access
    // they must stay steady until the second extension byte has been taken.
    assign base_ptr = circ_enable ? ptr_add(circular_buffer_start, coefficient_pointer)
                                  : coefficient_pointer;

    assign offset_k = {ext_byte, ext_lo};

    // ------------------------------------------------------------
    // Address pairing
    // ------------------------------------------------------------
    cptr_pair_addr #(
        .AW          (ADDR_W)
    ) u_pair (
        .first_addr  (next_addr_first),
        .second_addr (pair_addr)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state               = state;
        next_ext_lo              = ext_lo;
        next_held_long           = held_long;
        next_held_load           = held_load;
        next_held_reg            = held_reg;
        next_pend_reg            = pend_reg;
        next_pend_long           = pend_long;
        next_pend                = 1'b0;
        next_coefficient_pointer = coefficient_pointer;
        next_pointer_high_part   = pointer_high_part;
        next_addr_valid          = 1'b0;
        next_addr_long           = addr_long;
        next_addr_first          = addr_first;
        next_busy                = busy;
        next_no_parallel         = no_parallel;

        // The high part reloads in any state; a same-cycle access still sees the old one.
        if (high_load) begin
            next_pointer_high_part = high_load_value;
        end

        case (state)
            ST_IDLE: begin
                // Requests and pointer loads are taken only here; while an offset access
                // waits they are dropped without notice, which keeps its base fixed.
                if (ptr_load) begin
                    next_coefficient_pointer = ptr_load_value;
                end
                if (req_valid) begin
                    next_held_long = req_long;
                    next_held_load = req_load;
                    next_held_reg  = req_dest_reg;
                    case (addr_mode_e'(req_mode))
                        MODE_POST_INC: begin
                            next_addr_valid = 1'b1;
                            next_addr_long  = req_long;
                            next_addr_first = join_addr(pointer_high_part, base_ptr);
                            next_coefficient_pointer = ptr_add(coefficient_pointer,
                                step_size(req_long));
                        end
                        MODE_POST_DEC: begin
                            next_addr_valid = 1'b1;
                            next_addr_long  = req_long;
                            next_addr_first = join_addr(pointer_high_part, base_ptr);
                            next_coefficient_pointer = ptr_sub(coefficient_pointer,
                                step_size(req_long));
                        end
                        MODE_OFFSET: begin
                            next_state       = ST_EXT_L;
                            next_busy        = 1'b1;
                            next_no_parallel = 1'b1;
                        end
                        default: begin
                            next_addr_valid = 1'b1;
                            next_addr_long  = req_long;
                            next_addr_first = join_addr(pointer_high_part, base_ptr);
                        end
                    endcase
                end
            end
            ST_EXT_L: begin
                if (ext_valid) begin
                    next_ext_lo = ext_byte;
                    next_state  = ST_EXT_H;
                end
            end
            ST_EXT_H: begin
                if (ext_valid) begin
                    next_addr_valid = 1'b1;
                    next_addr_long  = held_long;
                    next_addr_first = join_addr(pointer_high_part,
                                                ptr_add(base_ptr, offset_k));
                    next_state       = ST_IDLE;
                    next_busy        = 1'b0;
                    next_no_parallel = 1'b0;
                end
            end
            default: begin
                next_state       = ST_IDLE;
                next_busy        = 1'b0;
                next_no_parallel = 1'b0;
            end
        endcase

        // Only one load is tracked: a newer address replaces an unanswered older load,
        // so the memory must not answer the older one after the newer address is out.
        if (next_addr_valid) begin
            next_pend      = next_held_load;
            next_pend_reg  = next_held_reg;
            next_pend_long = next_addr_long;
        end else if (pend && !rd_valid) begin
            next_pend = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Write back
    // ------------------------------------------------------------
    // first word lower register
    always_comb begin
        next_wb_valid   = pend && rd_valid;
        next_wb_pair    = pend_long;
        next_wb_reg_lo  = pend_reg;
        next_wb_data_lo = rd_word_first;
        next_wb_reg_hi  = REG_W'(pend_reg + REG_W'(1));
        next_wb_data_hi = pend_long ? rd_word_second : PTR_RESET;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state               <= ST_IDLE;
            ext_lo              <= '0;
            held_long           <= 1'b0;
            held_load           <= 1'b0;
            held_reg            <= '0;
            pend_reg            <= '0;
            pend_long           <= 1'b0;
            pend                <= 1'b0;
            coefficient_pointer <= PTR_RESET;
            pointer_high_part   <= HIGH_RESET;
            addr_valid          <= 1'b0;
            addr_long           <= 1'b0;
            addr_first          <= '0;
            addr_second         <= '0;
            busy                <= 1'b0;
            no_parallel         <= 1'b0;
            wb_valid            <= 1'b0;
            wb_pair             <= 1'b0;
            wb_reg_lo           <= '0;
            wb_data_lo          <= '0;
            wb_reg_hi           <= '0;
            wb_data_hi          <= '0;
        end else begin
            state               <= next_state;
            ext_lo              <= next_ext_lo;
            held_long           <= next_held_long;
            held_load           <= next_held_load;
            held_reg            <= next_held_reg;
            pend_reg            <= next_pend_reg;
            pend_long           <= next_pend_long;
            pend                <= next_pend;
            coefficient_pointer <= next_coefficient_pointer;
            pointer_high_part   <= next_pointer_high_part;
            addr_valid          <= next_addr_valid;
            addr_long           <= next_addr_long;
            addr_first          <= next_addr_first;
            addr_second         <= pair_addr;
            busy                <= next_busy;
            no_parallel         <= next_no_parallel;
            wb_valid            <= next_wb_valid;
            wb_pair             <= next_wb_pair;
            wb_reg_lo           <= next_wb_reg_lo;
            wb_data_lo          <= next_wb_data_lo;
            wb_reg_hi           <= next_wb_reg_hi;
            wb_data_hi          <= next_wb_data_hi;
        end
    end

endmodule

`default_nettype wire

//--- dv/cptr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------
// Memory answering each address pair
// -----------------------------------------
module cptr_mem_model
    import cptr_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              slow,
    input  wire logic              addr_valid,
    input  wire logic [ADDR_W-1:0] addr_first,
    input  wire logic [ADDR_W-1:0] addr_second,
    output logic                   rd_valid,
    output logic [PTR_W-1:0]       rd_word_first,
    output logic [PTR_W-1:0]       rd_word_second
);
    logic [PTR_W-1:0] w1;
    logic [PTR_W-1:0] w2;
    int               wait_n;

    // Idle words flip every cycle so a stale read never looks valid.
    initial begin
        rd_valid = 1'b0;
        rd_word_first = 16'h0000;
        rd_word_second = 16'hFFFF;
        wait_n = -1;
        forever begin
            @(negedge core_clk);
            if (addr_valid === 1'b1) begin
                w1 = addr_first[PTR_W-1:0] ^ 16'h5A3C;
                w2 = addr_second[PTR_W-1:0] ^ 16'h5A3C;
                wait_n = slow ? 2 : 0;
            end
            rd_valid <= (wait_n == 0);
            if (wait_n == 0) begin
                rd_word_first <= w1;
                rd_word_second <= w2;
            end else begin
                rd_word_first <= ~rd_word_first;
                rd_word_second <= ~rd_word_second;
            end
            if (wait_n >= 0) begin
                wait_n--;
            end
        end
    end
endmodule

`default_nettype wire

//--- dv/cptr_sva.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------
// Port checks
// -----------------------------------------
module cptr_sva
    import cptr_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic              ptr_load,
    input wire logic              circ_enable,
    input wire logic [PTR_W-1:0]  circular_buffer_start,
    input wire logic              req_valid,
    input wire logic [1:0]        req_mode,
    input wire logic              req_long,
    input wire logic              rd_valid,
    input wire logic [PTR_W-1:0]  rd_word_first,
    input wire logic [PTR_W-1:0]  rd_word_second,
    input wire logic              addr_valid,
    input wire logic              addr_long,
    input wire logic [ADDR_W-1:0] addr_first,
    input wire logic [ADDR_W-1:0] addr_second,
    input wire logic              busy,
    input wire logic              no_parallel,
    input wire logic              wb_valid,
    input wire logic              wb_pair,
    input wire logic [REG_W-1:0]  wb_reg_lo,
    input wire logic [REG_W-1:0]  wb_reg_hi,
    input wire logic [PTR_W-1:0]  wb_data_lo,
    input wire logic [PTR_W-1:0]  wb_data_hi,
    input wire logic [PTR_W-1:0]  coefficient_pointer,
    input wire logic [HIGH_W-1:0] pointer_high_part
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic take;
    assign take = req_valid && !busy && !ptr_load;

    a_inc_word: assert property (take && req_mode == 2'b01 && !req_long
        |=> coefficient_pointer == $past(coefficient_pointer) + 16'h0001) else $error("inc1");
    a_inc_long: assert property (take && req_mode == 2'b01 && req_long
        |=> coefficient_pointer == $past(coefficient_pointer) + 16'h0002) else $error("inc2");
    a_dec_word: assert property (take && req_mode == 2'b10 && !req_long
        |=> coefficient_pointer == $past(coefficient_pointer) - 16'h0001) else $error("dec1");
    a_dec_long: assert property (take && req_mode == 2'b10 && req_long
        |=> coefficient_pointer == $past(coefficient_pointer) - 16'h0002) else $error("dec2");
    a_base_addr: assert property (take && req_mode != 2'b11
        |=> addr_valid && addr_long == $past(req_long) && addr_first == {$past(pointer_high_part),
        16'($past(coefficient_pointer) + ($past(circ_enable) ? $past(circular_buffer_start)
        : 16'h0000))}) else $error("address");
    a_pair_addr: assert property (addr_valid && addr_long
        |-> addr_second == (addr_first[0] ? addr_first - 1'b1 : addr_first + 1'b1))
        else $error("second address");
    a_offset_keep: assert property ((take && req_mode == 2'b11) || busy
        |=> coefficient_pointer == $past(coefficient_pointer)) else $error("pointer moved");
    a_offset_busy: assert property (take && req_mode == 2'b11
        |=> busy && no_parallel) else $error("offset not busy");
    a_no_pair: assert property (no_parallel == busy) else $error("pairing flag");
    a_ext_wait: assert property ($fell(busy)
        |-> addr_valid) else $error("offset address late");
    a_wb_order: assert property (wb_valid
        |-> $past(rd_valid) && wb_data_lo == $past(rd_word_first) && (!wb_pair ||
        (wb_reg_hi == wb_reg_lo + 5'h01 && wb_data_hi == $past(rd_word_second))))
        else $error("write back");
endmodule

bind coeff_pointer_address_gen cptr_sva u_sva (.core_clk, .rstn, .ptr_load, .circ_enable,
    .circular_buffer_start, .req_valid, .req_mode, .req_long, .rd_valid, .rd_word_first,
    .rd_word_second, .addr_valid, .addr_long, .addr_first, .addr_second, .busy, .no_parallel,
    .wb_valid, .wb_pair, .wb_reg_lo, .wb_reg_hi, .wb_data_lo, .wb_data_hi,
    .coefficient_pointer, .pointer_high_part);

`default_nettype wire

//--- dv/coeff_pointer_address_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none

module coeff_pointer_address_gen_tb
    import cptr_pkg::*;
;
    logic              core_clk, rstn, ptr_load, high_load, circ_enable, req_valid;
    logic              req_long, req_load, ext_valid, slow, rd_valid, addr_valid;
    logic              addr_long, busy, no_parallel, wb_valid, wb_pair;
    logic [1:0]        req_mode;
    logic [EXT_W-1:0]  ext_byte;
    logic [HIGH_W-1:0] high_load_value, pointer_high_part;
    logic [REG_W-1:0]  req_dest_reg, wb_reg_lo, wb_reg_hi;
    logic [PTR_W-1:0]  ptr_load_value, circular_buffer_start, rd_word_first, rd_word_second;
    logic [PTR_W-1:0]  wb_data_lo, wb_data_hi, coefficient_pointer;
    logic [ADDR_W-1:0] addr_first, addr_second;
    int                err_total, cmp_count, ptr, high;

    coeff_pointer_address_gen uut (.core_clk, .rstn, .ptr_load, .ptr_load_value, .high_load,
        .high_load_value, .circ_enable, .circular_buffer_start, .req_valid, .req_mode,
        .req_long, .req_load, .req_dest_reg, .ext_valid, .ext_byte, .rd_valid, .rd_word_first,
        .rd_word_second, .addr_valid, .addr_long, .addr_first, .addr_second, .busy,
        .no_parallel, .wb_valid, .wb_pair, .wb_reg_lo, .wb_data_lo, .wb_reg_hi, .wb_data_hi,
        .coefficient_pointer, .pointer_high_part);
    cptr_mem_model mem (.core_clk, .slow, .addr_valid, .addr_first, .addr_second, .rd_valid,
        .rd_word_first, .rd_word_second);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // -----------------------------------------
    // Checking and closing
    // -----------------------------------------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_for(ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (sig !== 1'b1) begin
            chk("wait", 32'h0, 32'h1);
            close_out();
        end
    endtask

    // One access in a random mode; the model steps its pointer as the design should.
    task automatic access();
        int mode, lng, ld, dest, off, base, first, second;
        mode = $urandom_range(3);
        lng = $urandom_range(1);
        ld = $urandom_range(1);
        dest = $urandom_range(30);
        off = $urandom_range(32'hFFFF);
        @(negedge core_clk);
        req_valid = 1'b1;
        req_mode = 2'(mode);
        req_long = lng[0];
        req_load = ld[0];
        req_dest_reg = 5'(dest);
        circ_enable = 1'($urandom_range(1));
        circular_buffer_start = 16'($urandom);
        slow = 1'($urandom_range(1));
        base = ptr + (circ_enable ? int'(circular_buffer_start) : 0);
        base = (base + (mode == 3 ? off : 0)) & 32'hFFFF;
        first = (high << 16) | base;
        second = first[0] ? first - 1 : first + 1;
        if (mode == 1) ptr = (ptr + lng + 1) & 32'hFFFF;
        if (mode == 2) ptr = (ptr - lng - 1) & 32'hFFFF;
        @(negedge core_clk);
        // A stray offset request and pointer load while busy must both be dropped.
        req_valid = (mode == 3);
        ptr_load = (mode == 3);
        ptr_load_value = ~16'(ptr);
        if (mode == 3) begin
            chk("busy", busy, 1);
            chk("no_parallel", no_parallel, 1);
            ext_valid = 1'b1;
            ext_byte = 8'(off);
            @(negedge core_clk);
            {req_valid, ptr_load} = 2'b00;
            ext_byte = 8'(off >> 8);
            @(negedge core_clk);
            ext_valid = 1'b0;
        end
        wait_for(addr_valid);
        chk("addr_first", addr_first, first);
        chk("addr_long", addr_long, lng);
        if (lng) chk("addr_second", addr_second, second);
        chk("pointer", coefficient_pointer, ptr);
        if (ld) begin
            wait_for(wb_valid);
            chk("wb_reg_lo", wb_reg_lo, dest);
            chk("wb_data_lo", wb_data_lo, 16'(first) ^ 16'h5A3C);
            chk("wb_pair", wb_pair, lng);
            if (lng) chk("wb_reg_hi", wb_reg_hi, dest + 1);
            if (lng) chk("wb_data_hi", wb_data_hi, 16'(second) ^ 16'h5A3C);
        end
    endtask

    initial begin
        {err_total, cmp_count, ptr, high} = '0;
        {rstn, ptr_load, high_load, circ_enable, req_valid, req_long} = '0;
        {req_load, ext_valid, slow, req_mode, ext_byte, high_load_value} = '0;
        {req_dest_reg, ptr_load_value, circular_buffer_start} = '0;
        void'($urandom(32'h1fd096bd));
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        chk("reset pointer", coefficient_pointer, 0);
        chk("reset valid", addr_valid, 0);
        repeat (120) begin
            if ($urandom_range(3) == 0) begin
                ptr = ($urandom_range(1) == 1) ? 32'hFFFF : $urandom_range(32'hFFFF);
                high = $urandom_range(127);
                @(negedge core_clk);
                {ptr_load, high_load} = 2'b11;
                ptr_load_value = 16'(ptr);
                high_load_value = 7'(high);
                @(negedge core_clk);
                {ptr_load, high_load} = 2'b00;
                chk("high part", pointer_high_part, high);
            end
            access();
        end
        close_out();
    end
endmodule

`default_nettype wire
